// ==== pdm_defs.vh ====
// Purpose: constants for the process data mapper
// Assumes: 16-bit register bus, two bit-area stations
// Notes:   bit indexes count from the start of station m
//
// Contract
// R1 - Digital input pins reported on bits 2p/2p+1
// R2 - Digital output pins driven from RY bits
// R3 - Port payload at word 04h, 4-word blocks
// R4 - Own state machine, active only in cyclic
// R5 - Cyclic start enters initial processing
// R6 - Init-complete flag starts operation with settings
// R7 - Reconfig request applies config, suspends exchange
// R8 - Device raises reconfig-complete flag when applied
// R9 - Request cleared: resume with new config
// R10 - Reconfig touches only cyclic image config; the code also applies the C0h profile register
// R11 - Station holds 64 bits and 32 words
// R12 - Profiles P1-P4: 8 to 32 bytes
// R13 - Bit layout same for every profile
// R14 - Word area carries status plus payload
// R15 - Same size both directions, two bytes/word
// R16 - Little-endian packing unless byte swap set
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH

// Station geometry
`define PDM_STA_BITS    64
`define PDM_STA_WORDS   32
`define PDM_MEM_WORDS   160

// Word area layout
`define PDM_PD_BASE     8'h04
`define PDM_WPP_UNIT    5'h04
`define PDM_STAT_WORDS  8'h04

// Bit area indexes (station m counts from 0)
`define PDM_RY_DIR      16
`define PDM_RY_IOLEN    48
`define PDM_RY_SWAP     64
`define PDM_RY_INITDONE 72
`define PDM_RY_RCFGREQ  73
`define PDM_RX_EST      48
`define PDM_RX_VALID    64
`define PDM_RX_RCFGDONE 72
`define PDM_RX_INITBUSY 73

// Register bus map
`define PDM_A_BIT_LO    8'hA0
`define PDM_A_BIT_HI    8'hA7
`define PDM_A_PROF      8'hC0
`define PDM_A_ISTAT     8'hC1
`define PDM_A_IEN       8'hC2
`define PDM_A_ICLR      8'hC3
`define PDM_A_STATE     8'hC4

// Reset values
`define PDM_PROF_RST    2'h0
`define PDM_IEN_RST     4'h0

`endif

// ==== pdm_mapper.v ====
// Purpose: maps eight sensor ports onto the cyclic process image
//          and sequences the application states
// Assumes: cyclic_active and the port engines run on mclk;
//          pin inputs are asynchronous
// Notes:   RWw and RWr share word addresses 00h-9Fh: writes land in
//          the output image, reads come from the input image above the four status words at 00h-03h;
//          input words read unknown until a port engine fills them

`include "pdm_defs.vh"

module pdm_mapper #(
    parameter MEM_WORDS = `PDM_MEM_WORDS
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        nrst,
    // Register bus
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Fieldbus protocol status
    input  wire        cyclic_active,
    // Port pins, bit 2p is pin 4, bit 2p+1 is pin 2
    input  wire [15:0] pin_i,
    output reg  [15:0] pin_o,
    output wire [15:0] pin_oe,
    // Input process_payload from the port engines
    input  wire        pdi_valid,
    input  wire [2:0]  pdi_port,
    input  wire [3:0]  pdi_idx,
    input  wire [15:0] pdi_data,
    // Output process_payload to the port engines
    input  wire        pdo_rd,
    input  wire [2:0]  pdo_port,
    input  wire [3:0]  pdo_idx,
    output reg  [15:0] pdo_data,
    output wire [7:0]  iol_enable,
    // Status
    output wire [1:0]  app_state,
    output wire        irq
);

    localparam ST_IDLE = 2'b00;
    localparam ST_INIT = 2'b01;
    localparam ST_OPER = 2'b10;
    localparam ST_RCFG = 2'b11;

    // First word of a port's payload block
    function [7:0] pdm_base;
        input [2:0] port;
        input [1:0] prof;
        begin
            pdm_base = `PDM_PD_BASE + {5'h00, port} * {3'h0, pdm_wpp(prof)}; // see R3
        end
    endfunction

    // Words per port for a profile: 4, 8, 12 or 16
    function [4:0] pdm_wpp;
        input [1:0] prof;
        begin
            pdm_wpp = ({3'h0, prof} + 5'h01) * `PDM_WPP_UNIT; // see R12
        end
    endfunction

    // Byte order of one word
    function [15:0] pdm_swap;
        input [15:0] w;
        input        s;
        begin
            pdm_swap = s ? {w[7:0], w[15:8]} : w; // see R16
        end
    endfunction

    // Spread a per-port mask onto the pin 4 positions
    function [15:0] pdm_pin4;
        input [7:0] m;
        integer k;
        begin
            pdm_pin4 = 16'h0000;
            for (k = 0; k < 8; k = k + 1) begin
                pdm_pin4[2 * k] = m[k];
            end
        end
    endfunction

    // Register write strobe aimed at one address
    function pdm_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] target;
        begin
            pdm_hit = wr && (addr == target);
        end
    endfunction

    // Word index inside the block of the applied profile
    function pdm_in_block;
        input [3:0] idx;
        input [4:0] words;
        begin
            pdm_in_block = ({1'b0, idx} < words);
        end
    endfunction

    // Word address of one payload word
    function [7:0] pdm_addr;
        input [2:0] port;
        input [3:0] idx;
        input [1:0] prof;
        begin
            pdm_addr = pdm_base(port, prof) + {4'h0, idx}; // see R3
        end
    endfunction

    // Bit area, two stations, same layout for every profile
    reg  [127:0] ry_r;                            // see R11, R13
    wire [127:0] rx_w;

    // Word area images
    reg  [15:0]  rww_r [0:MEM_WORDS-1];
    reg  [15:0]  rwr_r [0:MEM_WORDS-1];

    // Control and applied configuration
    reg  [1:0]   state_r;
    reg  [1:0]   state_nxt;
    reg  [1:0]   prof_r;
    reg  [1:0]   act_prof_r;
    reg  [15:0]  act_dir_r;
    reg  [7:0]   act_iol_r;
    reg  [7:0]   act_swap_r;
    reg          rcfg_done_r;
    reg  [7:0]   valid_r;
    reg  [15:0]  din_r;
    reg  [15:0]  sync1_r;
    reg  [15:0]  sync2_r;
    reg  [3:0]   ist_r;
    reg  [3:0]   ien_r;
    reg  [15:0]  rd_val;

    wire         oper;
    wire         apply;
    wire         init_done;
    wire         rcfg_req;
    wire [15:0]  iol_pins;
    wire [15:0]  dig_out;
    wire [15:0]  dig_in;
    wire [4:0]   wpp;
    wire         pdi_ok;
    wire         pdo_ok;
    wire [7:0]   pdi_addr;
    wire [7:0]   pdo_addr;
    wire [3:0]   ev;
    wire         bit_sel;
    wire [2:0]   bit_word;

    assign oper      = (state_r == ST_OPER);
    assign init_done = ry_r[`PDM_RY_INITDONE];
    assign rcfg_req  = ry_r[`PDM_RY_RCFGREQ];
    assign iol_pins  = pdm_pin4(act_iol_r);
    // Pin 2 never joins IO-Link, so only pin 4 is masked
    assign dig_out   = act_dir_r & ~iol_pins;             // see R2
    assign dig_in    = ~act_dir_r & ~iol_pins;            // see R1
    assign pin_oe    = dig_out;
    assign iol_enable = act_iol_r;
    assign app_state = state_r;
    assign wpp       = pdm_wpp(act_prof_r);
    assign bit_sel   = (reg_addr >= `PDM_A_BIT_LO) && (reg_addr <= `PDM_A_BIT_HI);
    assign bit_word  = reg_addr[2:0];

    // Applied config follows the image in these two moments only
    assign apply = ((state_r == ST_INIT) && init_done) ||  // see R6
                   (state_r == ST_RCFG);                    // see R7

    // Payload addresses, same block size in both directions
    // An index past the block end is dropped, never spilled into the next port
    assign pdi_addr = pdm_addr(pdi_port, pdi_idx, act_prof_r);  // see R15
    assign pdo_addr = pdm_addr(pdo_port, pdo_idx, act_prof_r);
    assign pdi_ok   = pdi_valid && oper && act_iol_r[pdi_port] &&
                      pdm_in_block(pdi_idx, wpp);          // see R7
    assign pdo_ok   = oper && act_iol_r[pdo_port] && pdm_in_block(pdo_idx, wpp);

    // RX bit area seen by the master
    assign rx_w[15:0]                   = din_r;           // see R1
    assign rx_w[`PDM_RX_EST-1:16]       = 32'h0000_0000;
    assign rx_w[`PDM_RX_EST+7:`PDM_RX_EST] = oper ? act_iol_r : 8'h00;
    assign rx_w[`PDM_RX_VALID-1:`PDM_RX_EST+8] = 8'h00;
    assign rx_w[`PDM_RX_VALID+7:`PDM_RX_VALID] = valid_r;
    assign rx_w[`PDM_RX_RCFGDONE]       = rcfg_done_r;     // see R8
    assign rx_w[`PDM_RX_INITBUSY]       = (state_r == ST_INIT);
    assign rx_w[127:`PDM_RX_INITBUSY+1] = 54'h0;

    // Events: cyclic start, operation entered, reconfig entered, reconfig done
    // Each lasts one cycle; the sticky status bits keep it for software
    assign ev[0] = (state_r == ST_IDLE) && (state_nxt == ST_INIT);
    assign ev[1] = (state_r != ST_OPER) && (state_nxt == ST_OPER);
    assign ev[2] = (state_r == ST_OPER) && (state_nxt == ST_RCFG);
    assign ev[3] = (state_r == ST_RCFG) && !rcfg_done_r;
    assign irq   = |(ist_r & ien_r);

    // Application sequencer, forced idle whenever cyclic stops
    always @* begin
        state_nxt = state_r;
        if (!cyclic_active) begin
            state_nxt = ST_IDLE;                           // see R4
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_INIT;                   // see R5
                end
                ST_INIT: begin
                    if (init_done) begin
                        state_nxt = ST_OPER;               // see R6
                    end
                end
                ST_OPER: begin
                    if (rcfg_req) begin
                        state_nxt = ST_RCFG;               // see R7
                    end
                end
                ST_RCFG: begin
                    // Leave only after completion was shown
                    if (rcfg_done_r && !rcfg_req) begin
                        state_nxt = ST_OPER;               // see R9
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // State, config and interrupt registers
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r     <= ST_IDLE;
            prof_r      <= `PDM_PROF_RST;
            act_prof_r  <= `PDM_PROF_RST;
            act_dir_r   <= 16'h0000;
            act_iol_r   <= 8'h00;
            act_swap_r  <= 8'h00;
            rcfg_done_r <= 1'b0;
            ist_r       <= 4'h0;
            ien_r       <= `PDM_IEN_RST;
        end else begin
            state_r <= state_nxt;
            // Image config plus the C0h profile are taken; bus registers stay untouched
            if (apply) begin
                act_dir_r  <= ry_r[`PDM_RY_DIR+15:`PDM_RY_DIR];   // see R10
                act_iol_r  <= ry_r[`PDM_RY_IOLEN+7:`PDM_RY_IOLEN];
                act_swap_r <= ry_r[`PDM_RY_SWAP+7:`PDM_RY_SWAP];
                act_prof_r <= prof_r;                             // see R12
            end
            // Done flag one cycle after the first apply
            rcfg_done_r <= (state_r == ST_RCFG) && (state_nxt == ST_RCFG); // see R8
            if (pdm_hit(reg_wr, reg_addr, `PDM_A_PROF)) begin
                prof_r <= reg_wdata[1:0];
            end
            if (pdm_hit(reg_wr, reg_addr, `PDM_A_IEN)) begin
                ien_r <= reg_wdata[3:0];
            end
            // A new event wins over a clear in the same cycle
            if (pdm_hit(reg_wr, reg_addr, `PDM_A_ICLR)) begin
                ist_r <= (ist_r & ~reg_wdata[3:0]) | ev;
            end else begin
                ist_r <= ist_r | ev;
            end
        end
    end

    // RY image written by the master at any time
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ry_r <= 128'h0;
        end else if (reg_wr && bit_sel) begin
            ry_r[{bit_word, 4'h0} +: 16] <= reg_wdata;
        end
    end

    // Pin input synchroniser, second stage feeds the mapper
    // Pins are asynchronous, so nothing but the second stage reads the first
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end

    // Digital exchange, cleared in idle, frozen in init and reconfiguration
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            din_r <= 16'h0000;
            pin_o <= 16'h0000;
        end else if (state_r == ST_IDLE) begin
            // Lost link: drop outputs to a safe level
            din_r <= 16'h0000;
            pin_o <= 16'h0000;
        end else if (oper) begin
            din_r <= sync2_r & dig_in;                     // see R1
            pin_o <= ry_r[15:0] & dig_out;                 // see R2
        end
    end

    // Data valid per port, only meaningful in operation
    // Cleared outside operation so no stale flag survives a reconfiguration
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            valid_r <= 8'h00;
        end else if (!oper) begin
            valid_r <= 8'h00;                              // see R7
        end else if (pdi_ok) begin
            valid_r[pdi_port] <= 1'b1;
        end
    end

    // Word images; memories carry no reset
    always @(posedge mclk) begin
        if (reg_wr && (reg_addr < `PDM_A_BIT_LO)) begin
            rww_r[reg_addr] <= reg_wdata;
        end
        if (pdi_ok) begin
            rwr_r[pdi_addr] <= pdm_swap(pdi_data, act_swap_r[pdi_port]); // see R3, R16
        end
    end

    // Output payload to the engines, fetches return zero when suspended
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pdo_data <= 16'h0000;
        end else if (pdo_rd) begin
            pdo_data <= pdo_ok ? pdm_swap(rww_r[pdo_addr], act_swap_r[pdo_port])
                               : 16'h0000;                 // see R7, R16
        end
    end

    // Read decode; status words lead the word area
    always @* begin
        rd_val = 16'h0000;
        if (reg_addr < `PDM_STAT_WORDS) begin
            case (reg_addr[1:0])                           // see R14
                2'h0: rd_val = {11'h000, rcfg_done_r, act_prof_r, state_r};
                2'h1: rd_val = din_r;
                2'h2: rd_val = {valid_r, act_iol_r};
                default: rd_val = {8'h00, act_swap_r};
            endcase
        end else if (reg_addr < `PDM_A_BIT_LO) begin
            // No reset on this memory: unwritten words read unknown
            rd_val = rwr_r[reg_addr];
        end else if (bit_sel) begin
            rd_val = rx_w[{bit_word, 4'h0} +: 16];
        end else begin
            case (reg_addr)
                `PDM_A_PROF:  rd_val = {14'h0000, prof_r};
                `PDM_A_ISTAT: rd_val = {12'h000, ist_r};
                `PDM_A_IEN:   rd_val = {12'h000, ien_r};
                `PDM_A_STATE: rd_val = {14'h0000, state_r};
                default:      rd_val = 16'h0000;
            endcase
        end
    end

    // Read data stands for one cycle only
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_val;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // pdm_mapper

// ==== pdm_mapper_sva.sv ====
// Purpose: concurrent checks on the mapper's sequencer and pin ports
// Assumes: single mclk domain, nrst asynchronous active low
// Notes:   state codes 0 idle, 1 init, 2 operation, 3 reconfiguration
module pdm_mapper_sva (
    // Clock and reset
    input logic        mclk,
    input logic        nrst,
    // Register bus
    input logic [7:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    // Status and pins
    input logic        cyclic_active,
    input logic [15:0] pin_oe,
    input logic        pdo_rd,
    input logic [15:0] pdo_data,
    input logic [7:0]  iol_enable,
    input logic [1:0]  app_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Control word A4h: bit 8 init done, bit 9 reconfig request
    sequence s_init_wr;
        app_state == 2'd1 && reg_wr && reg_addr == 8'hA4 && reg_wdata[8];
    endsequence
    sequence s_rcfg_wr;
        app_state == 2'd2 && reg_wr && reg_addr == 8'hA4 && reg_wdata[9];
    endsequence
    // Pin 4 drive enables, one per port
    wire [7:0] oe4 = {pin_oe[14], pin_oe[12], pin_oe[10], pin_oe[8],
                      pin_oe[6], pin_oe[4], pin_oe[2], pin_oe[0]};

    a_idle_drop: assert property (!cyclic_active |=> app_state == 2'd0)
        else $error("state not idle after cyclic stop");
    a_start_init: assert property (app_state == 2'd0 && cyclic_active |=> app_state == 2'd1)
        else $error("cyclic start did not enter init");
    a_init_done: assert property (s_init_wr ##1 cyclic_active[*2] |-> ##[0:1] app_state == 2'd2)
        else $error("init done did not start operation");
    a_rcfg_enter: assert property (s_rcfg_wr ##1 cyclic_active[*2] |-> ##[0:1] app_state == 2'd3)
        else $error("request did not enter reconfiguration");
    a_state_order: assert property ($changed(app_state) |-> app_state == 2'd0 ||
        app_state == $past(app_state) + 2'd1 || ($past(app_state) == 2'd3 && app_state == 2'd2))
        else $error("illegal state step");
    a_pdo_quiet: assert property (pdo_rd && app_state != 2'd2 |=> pdo_data == 16'h0000)
        else $error("payload fetched outside operation");
    a_iol_undriven: assert property ((oe4 & iol_enable) == 8'h00)
        else $error("IO-Link pin driven as output");
    a_cfg_stable: assert property (app_state == 2'd2 && $past(app_state) == 2'd2 |-> $stable(iol_enable))
        else $error("applied config moved during operation");
endmodule // pdm_mapper_sva

bind pdm_mapper pdm_mapper_sva i_sva (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .cyclic_active,
    .pin_oe, .pdo_rd, .pdo_data, .iol_enable, .app_state);

// ==== pdm_plc.sv ====
// Purpose: fieldbus master model on the register bus and cyclic status
// Assumes: strobes launched by non-blocking assignment after a rising edge
// Notes:   own polling reads raise own_rd so the bench skips them
module pdm_plc (
    // Clock
    input  wire         mclk,
    // Register bus
    output logic [7:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd,
    input  wire  [15:0] reg_rdata,
    // Protocol status and poll marker
    output logic        cyclic_active,
    output logic        own_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, cyclic_active, own_rd} = '0;
    end
    task automatic cyc(input logic v);
        @(posedge mclk);
        cyclic_active <= v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic init_done(input logic [15:0] swp);
        wr(8'hA4, 16'h0100 | swp);
    endtask
    // Bounded poll, a stuck device shows up as a wrong state later
    task automatic reconfig(input logic [15:0] swp, input logic [15:0] prof);
        logic [15:0] v;
        wr(8'hC0, prof);
        wr(8'hA4, 16'h0300 | swp);
        own_rd = 1'b1;
        v = 16'h0000;
        for (int n = 0; n < 20 && !v[8]; n++) rd(8'hA4, v);
        own_rd = 1'b0;
        wr(8'hA4, 16'h0100 | swp);
    endtask
endmodule // pdm_plc

// ==== process_data_mapper_fsm_test.sv ====
// Purpose: self-checking bench for the process data mapper
// Assumes: 40 MHz mclk, reset held 10 cycles, profiles P1, P2 then P4
// Notes:   unwritten input words read unknown, so only written ones are read
module process_data_mapper_fsm_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    wire  [7:0]  reg_addr;
    wire  [15:0] reg_wdata, reg_rdata, pin_o, pin_oe, pdo_data;
    wire         reg_wr, reg_rd, cyclic_active, own_rd, irq;
    wire  [7:0]  iol_enable;
    wire  [1:0]  app_state;
    logic [15:0] pin_i = '0, pdi_data = '0, dir, ry, pi, d;
    logic        pdi_valid = 1'b0, pdo_rd = 1'b0, rd_prev = 1'b0, pdo_prev = 1'b0;
    logic [2:0]  pdi_port = '0, pdo_port = '0;
    logic [3:0]  pdi_idx = '0, pdo_idx = '0;
    logic [15:0] exp_q[$], msk_q[$];
    int          failures = 0, checks = 0;

    always #12.5 mclk = ~mclk;

    pdm_plc i_plc (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cyclic_active, .own_rd);
    pdm_mapper i_dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cyclic_active, .pin_i, .pin_o, .pin_oe, .pdi_valid, .pdi_port, .pdi_idx, .pdi_data,
        .pdo_rd, .pdo_port, .pdo_idx, .pdo_data, .iol_enable, .app_state, .irq);

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        logic [15:0] v;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        i_plc.rd(a, v);
    endtask
    task automatic pdi(input logic [2:0] p, input logic [3:0] x, input logic [15:0] v);
        @(posedge mclk);
        pdi_valid <= 1'b1;
        pdi_port  <= p;
        pdi_idx   <= x;
        pdi_data  <= v;
        @(posedge mclk);
        pdi_valid <= 1'b0;
    endtask
    task automatic pdo(input logic [2:0] p, input logic [3:0] x, input logic [15:0] e);
        exp_q.push_back(e);
        msk_q.push_back(16'hFFFF);
        @(posedge mclk);
        pdo_rd   <= 1'b1;
        pdo_port <= p;
        pdo_idx  <= x;
        @(posedge mclk);
        pdo_rd   <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Results stand one cycle after their strobe, oldest note first
    always @(negedge mclk) begin
        if ((rd_prev || pdo_prev) && exp_q.size() > 0)
            chk(rd_prev ? "reg_rdata" : "pdo_data", (rd_prev ? reg_rdata : pdo_data) & msk_q.pop_front(), exp_q.pop_front());
        rd_prev = reg_rd && !own_rd;
        pdo_prev = pdo_rd;
    end

    // Whole run is about 130 cycles
    initial begin
        #100us;
        failures++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h1d1d3a71));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rd_exp(8'hC0, 16'h0000, 16'hFFFF);
        rd_exp(8'hC4, 16'h0000, 16'hFFFF);
        rd_exp(8'hB0, 16'h0000, 16'hFFFF);
        $display("test reset done");
        i_plc.cyc(1'b1);
        repeat (3) @(posedge mclk);
        rd_exp(8'hC4, 16'h0001, 16'hFFFF);
        i_plc.wr(8'hC1, 16'h0000);
        i_plc.wr(8'hC2, 16'h0001);
        rd_exp(8'hC1, 16'h0001, 16'h0001);
        chk("irq", {15'h0, irq}, 16'h0001);
        i_plc.wr(8'hC3, 16'h0001);
        @(negedge mclk);
        chk("irq", {15'h0, irq}, 16'h0000);
        $display("test start done");
        dir = 16'($urandom());
        ry = 16'($urandom());
        i_plc.wr(8'hA1, dir);
        i_plc.wr(8'hA3, 16'h0083);
        i_plc.wr(8'hA0, ry);
        pdo(3'd0, 4'd0, 16'h0000);
        i_plc.init_done(16'h0000);
        repeat (3) @(posedge mclk);
        rd_exp(8'hC4, 16'h0002, 16'hFFFF);
        rd_exp(8'hC1, 16'h0002, 16'h0002);
        chk("irq", {15'h0, irq}, 16'h0000);
        chk("app_state", {14'h0, app_state}, 16'h0002);
        chk("iol_enable", {8'h0, iol_enable}, 16'h0083);
        chk("pin_oe", pin_oe, dir & 16'hBFFA);
        chk("pin_o", pin_o, ry & dir & 16'hBFFA);
        pi = 16'($urandom());
        @(posedge mclk);
        pin_i <= pi;
        repeat (5) @(posedge mclk);
        rd_exp(8'hA0, pi, ~dir & 16'hBFFA);
        $display("test digital done");
        d = 16'($urandom());
        pdi(3'd1, 4'd0, 16'hA55A);
        pdi(3'd0, 4'd4, 16'h1234);
        pdi(3'd0, 4'd0, d);
        pdi(3'd7, 4'd3, d);
        rd_exp(8'h23, d, 16'hFFFF);
        rd_exp(8'hA4, 16'h0083, 16'hFFFF);
        rd_exp(8'h02, 16'h8383, 16'hFFFF);
        rd_exp(8'h00, 16'h0002, 16'hFFFF);
        rd_exp(8'h04, d, 16'hFFFF);
        rd_exp(8'h08, 16'hA55A, 16'hFFFF);
        i_plc.wr(8'h04, ~d);
        pdo(3'd0, 4'd0, ~d);
        i_plc.reconfig(16'h0002, 16'h0001);
        repeat (3) @(posedge mclk);
        rd_exp(8'hC4, 16'h0002, 16'hFFFF);
        rd_exp(8'hC1, 16'h000C, 16'h000C);
        rd_exp(8'h00, 16'h0006, 16'hFFFF);
        rd_exp(8'hC2, 16'h0001, 16'hFFFF);
        pdi(3'd1, 4'd7, d);
        rd_exp(8'h13, {d[7:0], d[15:8]}, 16'hFFFF);
        i_plc.reconfig(16'h0002, 16'h0003);
        repeat (3) @(posedge mclk);
        pdi(3'd7, 4'd15, d);
        rd_exp(8'h83, d, 16'hFFFF);
        $display("test payload done");
        i_plc.cyc(1'b0);
        repeat (3) @(posedge mclk);
        rd_exp(8'hC4, 16'h0000, 16'hFFFF);
        chk("pin_o", pin_o, 16'h0000);
        repeat (3) @(posedge mclk);
        $display("test stop done");
        complete_run();
    end
endmodule // process_data_mapper_fsm_test
